// *** pvic_pkg.sv ***
/*
  Constants for the sixteen-input vectored interrupt controller.
  Assumes the CPU I/O address decode gives an 8-bit port address.
*/
package pvic_pkg;
  localparam int          NUM_IRQ           = 16;
  // Register I/O addresses
  localparam logic [7:0]  ADDR_GRP_SVC_LO   = 8'h34;
  localparam logic [7:0]  ADDR_GRP_SVC_HI   = 8'h35;
  localparam logic [7:0]  ADDR_BLOCK_LO     = 8'h36;
  localparam logic [7:0]  ADDR_VEC_BLOCK_HI = 8'h37;
  // Reset values
  localparam logic [15:0] RST_BLOCK         = 16'hffff;
  localparam logic [15:0] RST_TRIGGER       = 16'h0000;
  localparam logic [15:0] RST_GROUP         = 16'h0000;
  localparam logic [2:0]  RST_VEC_BASE      = 3'h0;
  // Vector byte field positions
  localparam int          VEC_BASE_LSB      = 5;
  localparam int          VEC_IDX_LSB       = 1;
  // Interrupt source assignments
  localparam int          SRC_TIMER1        = 13;
  localparam int          SRC_TIMER0        = 12;
  localparam int          SRC_DMA_TC1       = 7;
  localparam int          SRC_DMA_TC0       = 6;
  localparam int          SRC_EXT_HI        = 15;
  localparam int          SRC_EXT_LO        = 14;
endpackage

// *** pvic_ctrl.sv ***
/*
  Vectored interrupt controller core: request latches, mask, priority
  groups, in-service tracking, vector return and illegal-interrupt state.
  Assumes the CPU shares i_ref_clk, drives synchronous I/O strobes and
  holds i_irq_ack_n low for at least one cycle per acknowledge.
*/
// How it works
// R01: Sixteen request inputs served by vectored acknowledge
// R02: Two groups; higher index wins within group
// R03: Qualified unmasked request drives active-low interrupt
// R04: Acknowledge places vector byte on data bus
// R05: End-of-service strobe low completes current routine
// R06: Ack, done and interrupt wire directly to CPU
// R07: Fixed source assignment of timer, DMA, pins
// R08: Vector base write switches write targets
// R09: Request latch: level follows, edge holds till service
// R10: Reset clears all edge detectors
// R11: Vector base gives vector bits seven to five
// R12: In-service set on ack, cleared, byte readable
// R13: Trigger mode per input, zero level, reset level
// R14: Software writes trigger mode before vector base
// R15: Group register per input, reset all LOW
// R16: Software writes group only after vector base
// R17: Timer inputs should use edge sensing
// R18: Vector is base, index, zero bit
// R19: HIGH group beats every LOW input
// R20: Mask bit one blocks input, reset all ones
// R21: End-of-service clears highest in-service level
// R22: Nested request forwarded only if it outranks
`timescale 1ns/10ps
module pvic_ctrl #(
  parameter int NUM_IRQ = pvic_pkg::NUM_IRQ
) (
  // Clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_n,
  // Request inputs; 13/12 timer 1/0, 7/6 DMA counts, 15/14 pins
  input  wire logic [15:0]  i_irq_request_in, // R07
  // CPU I/O port
  input  wire logic [7:0]   i_io_addr,
  input  wire logic [7:0]   i_io_wdata,
  input  wire logic         i_io_wr,
  input  wire logic         i_io_rd,
  output logic      [7:0]   o_io_rdata,
  // CPU interrupt handshake
  input  wire logic         i_irq_ack_n,
  input  wire logic         i_service_done_n,
  output logic              o_irq_n,
  output logic      [7:0]   o_vector,
  output logic              o_vector_oe
);

  typedef enum logic [1:0] {
    PVIC_IDLE    = 2'b00,
    PVIC_ACK     = 2'b01,
    PVIC_ILLEGAL = 2'b10
  } pvic_state_t;

  // Priority rank: group bit above index, so larger rank wins
  function automatic logic [4:0] pvic_rank(input logic grp, input logic [3:0] idx);
    pvic_rank = {grp, idx};
  endfunction

  // Best candidate among a set: returns found flag, index
  function automatic logic [4:0] pvic_pick(input logic [15:0] set, input logic [15:0] grp);
    logic [4:0] best;
    logic [5:0] best_rank;
    best      = 5'h00;
    best_rank = 6'h00;
    for (int n = 0; n < 16; n++) begin
      if (set[n] && ({1'b1, pvic_rank(grp[n], 4'(n))} > best_rank)) begin
        best      = {1'b1, 4'(n)};
        best_rank = {1'b1, pvic_rank(grp[n], 4'(n))};
      end
    end
    pvic_pick = best;
  endfunction

  logic [15:0]  trigger_mode_reg, trigger_mode_next;
  logic [15:0]  priority_group_reg, priority_group_next;
  logic [15:0]  irq_block_reg, irq_block_next;
  logic [2:0]   vector_base_reg, vector_base_next;
  logic         base_set_reg, base_set_next;
  logic [15:0]  in_service_reg, in_service_next;
  logic [15:0]  request_latch_reg, request_latch_next;
  logic [15:0]  prev_in_reg;
  pvic_state_t  state_reg, state_next;
  logic         ack_prev_reg;
  logic         done_prev_reg;
  logic [7:0]   vector_reg, vector_next;
  logic [7:0]   rdata_reg, rdata_next;

  logic [15:0]  rise;
  logic [15:0]  eligible;
  logic [4:0]   cand;
  logic [4:0]   svc_top;
  logic         outranks;
  logic         ack_fall;
  logic         done_fall;

  // Edge detectors cleared, strobe history set high by reset
  // A pin already high when reset lifts counts as a rise, by intent
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_in_reg   <= 16'h0000; // R10
      ack_prev_reg  <= 1'b1;
      done_prev_reg <= 1'b1;
    end else begin
      prev_in_reg   <= i_irq_request_in;
      ack_prev_reg  <= i_irq_ack_n;
      done_prev_reg <= i_service_done_n;
    end
  end

  assign rise      = i_irq_request_in & ~prev_in_reg;
  assign ack_fall  = ack_prev_reg & ~i_irq_ack_n;        // R06
  assign done_fall = done_prev_reg & ~i_service_done_n;  // R05

  // Arbitration over unmasked latched requests
  // Equal rank never nests, so an accepted level cannot re-request itself
  always_comb begin
    eligible = request_latch_reg & ~irq_block_reg;               // R20
    cand     = pvic_pick(eligible, priority_group_reg);          // R02 R19
    svc_top  = pvic_pick(in_service_reg, priority_group_reg);    // R21
    outranks = cand[4] && (!svc_top[4] ||
               pvic_rank(priority_group_reg[cand[3:0]], cand[3:0]) >
               pvic_rank(priority_group_reg[svc_top[3:0]], svc_top[3:0])); // R22
  end

  // Next-state for registers, latches, service tracking
  always_comb begin
    trigger_mode_next   = trigger_mode_reg;
    priority_group_next = priority_group_reg;
    irq_block_next      = irq_block_reg;
    vector_base_next    = vector_base_reg;
    base_set_next       = base_set_reg;
    in_service_next     = in_service_reg;
    state_next          = state_reg;
    vector_next         = vector_reg;
    rdata_next          = rdata_reg;
    // Level inputs follow the pin; edge inputs hold until serviced
    for (int n = 0; n < 16; n++) begin
      if (!trigger_mode_reg[n])
        request_latch_next[n] = i_irq_request_in[n];                 // R09 R13
      else
        request_latch_next[n] = request_latch_reg[n] | rise[n];      // R09
    end
    // Register writes; base write switches targets for 34h, 35h and 37h
    if (i_io_wr) begin
      unique case (i_io_addr)
        pvic_pkg::ADDR_GRP_SVC_LO: begin
          if (base_set_reg) priority_group_next[7:0] = i_io_wdata;  // R08 R15
          else              trigger_mode_next[7:0]   = i_io_wdata;  // R13
        end
        pvic_pkg::ADDR_GRP_SVC_HI: begin
          if (base_set_reg) priority_group_next[15:8] = i_io_wdata; // R08
          else              trigger_mode_next[15:8]   = i_io_wdata;
        end
        pvic_pkg::ADDR_BLOCK_LO: irq_block_next[7:0] = i_io_wdata;  // R20
        pvic_pkg::ADDR_VEC_BLOCK_HI: begin
          if (base_set_reg) irq_block_next[15:8] = i_io_wdata;      // R08
          else begin
            vector_base_next = i_io_wdata[7:5];                     // R11
            base_set_next    = 1'b1;                                // R08
          end
        end
        default: ;
      endcase
    end
    // Registered read data; in-service one byte at a time
    if (i_io_rd) begin
      unique case (i_io_addr)
        pvic_pkg::ADDR_GRP_SVC_LO:   rdata_next = in_service_reg[7:0];   // R12
        pvic_pkg::ADDR_GRP_SVC_HI:   rdata_next = in_service_reg[15:8];  // R12
        pvic_pkg::ADDR_BLOCK_LO:     rdata_next = irq_block_reg[7:0];
        pvic_pkg::ADDR_VEC_BLOCK_HI: rdata_next = irq_block_reg[15:8];
        default:                     rdata_next = 8'h00;
      endcase
    end
    // Acknowledge and end-of-service sequencing
    unique case (state_reg)
      PVIC_IDLE: begin
        if (ack_fall) begin
          if (outranks) begin
            in_service_next[cand[3:0]] = 1'b1;                           // R12
            if (trigger_mode_reg[cand[3:0]])
              request_latch_next[cand[3:0]] = rise[cand[3:0]];           // R09
            vector_next = {vector_base_reg, cand[3:0], 1'b0};            // R04 R18
            state_next  = PVIC_ACK;
          end else begin
            // Request vanished: answer as input 0, leave in-service alone
            vector_next = {vector_base_reg, 4'h0, 1'b0};
            state_next  = PVIC_ILLEGAL;
          end
        end else if (done_fall && svc_top[4]) begin
          in_service_next[svc_top[3:0]] = 1'b0;                          // R21 R05
        end
      end
      PVIC_ACK: begin
        if (i_irq_ack_n) state_next = PVIC_IDLE;
      end
      PVIC_ILLEGAL: begin
        // No acceptance until the done strobe; it clears nothing here
        if (done_fall) state_next = PVIC_IDLE;
      end
      default: state_next = PVIC_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trigger_mode_reg   <= pvic_pkg::RST_TRIGGER;   // R13
      priority_group_reg <= pvic_pkg::RST_GROUP;     // R15
      irq_block_reg      <= pvic_pkg::RST_BLOCK;     // R20
      vector_base_reg    <= pvic_pkg::RST_VEC_BASE;
      base_set_reg       <= 1'b0;
      in_service_reg     <= 16'h0000;
      request_latch_reg  <= 16'h0000;
      state_reg          <= PVIC_IDLE;
      vector_reg         <= 8'h00;
      rdata_reg          <= 8'h00;
    end else begin
      trigger_mode_reg   <= trigger_mode_next;
      priority_group_reg <= priority_group_next;
      irq_block_reg      <= irq_block_next;
      vector_base_reg    <= vector_base_next;
      base_set_reg       <= base_set_next;
      in_service_reg     <= in_service_next;
      request_latch_reg  <= request_latch_next;
      state_reg          <= state_next;
      vector_reg         <= vector_next;
      rdata_reg          <= rdata_next;
    end
  end

  // Interrupt is withheld while an acknowledge or illegal state runs
  assign o_irq_n     = !(outranks && state_reg == PVIC_IDLE);  // R03 R22 R01
  assign o_vector    = vector_reg;                             // R04
  // Vector drive ends with the acknowledge, not with the state change
  assign o_vector_oe = (state_reg != PVIC_IDLE) && !i_irq_ack_n;
  assign o_io_rdata  = rdata_reg;

  // Assertions
  a_vec_format: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R18
    $rose(o_vector_oe) |-> o_vector[0] == 1'b0 && o_vector[7:5] == vector_base_reg)
    else $error("vector byte format wrong");
  a_ack_sets_svc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    state_reg == PVIC_IDLE && ack_fall && outranks |=> in_service_reg[$past(cand[3:0])])
    else $error("accepted level not in service");
  a_irq_needs_req: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R03
    !o_irq_n |-> |(request_latch_reg & ~irq_block_reg))
    else $error("interrupt without unmasked request");
  a_mask_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R20
    (request_latch_reg & ~irq_block_reg) == 16'h0000 |-> o_irq_n)
    else $error("masked request raised interrupt");
  a_nest_rank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R22
    !o_irq_n && svc_top[4] |-> cand[4] && {priority_group_reg[cand[3:0]], cand[3:0]}
      > {priority_group_reg[svc_top[3:0]], svc_top[3:0]})
    else $error("nested request does not outrank");
  a_done_clears: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R21
    state_reg == PVIC_IDLE && done_fall && !ack_fall && svc_top[4]
      |=> !in_service_reg[$past(svc_top[3:0])])
    else $error("done strobe left level in service");
  a_level_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
    !trigger_mode_reg[0] && !i_irq_request_in[0] |=> !request_latch_reg[0])
    else $error("level latch did not follow input");
  a_base_switch: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R08
    base_set_reg && i_io_wr && i_io_addr == pvic_pkg::ADDR_GRP_SVC_LO
      |=> $stable(trigger_mode_reg))
    else $error("trigger mode written after base");
  a_high_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R19
    cand[4] && |(eligible & priority_group_reg) |-> priority_group_reg[cand[3:0]])
    else $error("low group beat high group");

  // Behaviour over time: latches hold, vector stands, in-service moves only when due
  a_edge_holds: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R09
    trigger_mode_reg[pvic_pkg::SRC_TIMER1] && request_latch_reg[pvic_pkg::SRC_TIMER1]
      && !ack_fall && !i_io_wr |=> request_latch_reg[pvic_pkg::SRC_TIMER1])
    else $error("edge request dropped before service");
  a_vec_stands: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R04
    o_vector_oe && $past(o_vector_oe) |-> $stable(o_vector))
    else $error("vector changed while driven");
  a_svc_clear_done: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R21
    !done_fall |=> ($past(in_service_reg) & ~in_service_reg) == 16'h0000)
    else $error("in-service cleared without done strobe");
  a_illegal_frozen: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    state_reg == PVIC_ILLEGAL |=> $stable(in_service_reg))
    else $error("in-service changed in illegal state");
  a_svc_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // R12
    i_io_rd && i_io_addr == pvic_pkg::ADDR_GRP_SVC_LO
      |=> o_io_rdata == $past(in_service_reg[7:0]))
    else $error("in-service read-back wrong");

  c_accept: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    state_reg == PVIC_IDLE && ack_fall && outranks);
  c_illegal: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    state_reg == PVIC_ILLEGAL);
  c_nested: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_irq_n && svc_top[4]);
  c_done: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    done_fall && svc_top[4]);
  c_edge_accept: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    state_reg == PVIC_IDLE && ack_fall && outranks && trigger_mode_reg[cand[3:0]]);

endmodule

// *** pvic_cpu_model.sv ***
/*
  Behavioural CPU core on the interrupt handshake: acknowledges a pending
  interrupt while the bench enables it, and pulses end-of-service on command.
  Assumes the bench shares i_ref_clk and changes commands just after an edge.
*/
`timescale 1ns/10ps
module pvic_cpu_model (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Controller side
  input  wire logic       i_irq_n,
  input  wire logic [7:0] i_vector,
  input  wire logic       i_vector_oe,
  output logic            o_ack_n,
  output logic            o_done_n,
  // Bench commands and observations
  input  wire logic       i_enable,
  input  wire logic       i_eoi,
  input  wire logic [1:0] i_delay,
  output logic            o_taken,
  output logic      [7:0] o_vec_seen
);
  int n;

  // Acknowledge held low until the vector is seen at a rising edge or 20 edges pass
  initial begin
    o_ack_n    = 1'b1;
    o_taken    = 1'b0;
    o_vec_seen = 8'h00;
    forever begin
      @(posedge i_ref_clk);
      if (!i_enable)
        o_taken = 1'b0;
      else if (i_rst_n && !i_irq_n && !o_taken) begin
        repeat (i_delay) @(posedge i_ref_clk); // Slow or prompt answer
        #1 o_ack_n = 1'b0;
        n = 0;
        do @(posedge i_ref_clk); while (i_vector_oe !== 1'b1 && ++n < 20);
        o_vec_seen = i_vector;
        #1 o_ack_n = 1'b1;
        o_taken = 1'b1;
      end
    end
  end

  // Return from service: one-cycle low pulse, never longer
  initial begin
    o_done_n = 1'b1;
    forever begin
      @(posedge i_ref_clk);
      if (i_eoi) begin
        #1 o_done_n = 1'b0;
        @(posedge i_ref_clk);
        #1 o_done_n = 1'b1;
      end
    end
  end
endmodule

// *** prioritized_vector_irq_ctrl_tb.sv ***
/*
  Self-checking bench for the vectored interrupt controller with a reference
  model of latches, masks, groups and in-service ranks.
  Assumes pvic_cpu_model answers the interrupt handshake.
*/
`timescale 1ns/10ps
module prioritized_vector_irq_ctrl_tb;
  // Design inputs
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] req = 16'h0000;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        en = 1'b0;
  logic        eoi = 1'b0;
  logic [1:0]  dly = 2'h0;
  // Design outputs and CPU observations
  logic [7:0]  rdata, vector, vec_seen;
  logic        irq_n, oe, ack_n, done_n, taken;
  // Reference state; timer inputs are edge sensed
  logic [31:0] seed = 32'h758e5c94;
  logic [15:0] trig = 16'h3000;
  logic [15:0] grp, msk, pend, elig;
  logic [2:0]  base;
  int          err_count = 0;
  int          n_tests = 0;
  int          w, k, j, it;

  pvic_ctrl i_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_irq_request_in(req), .i_io_addr(addr),
    .i_io_wdata(wdata), .i_io_wr(wr), .i_io_rd(rd), .o_io_rdata(rdata), .i_irq_ack_n(ack_n),
    .i_service_done_n(done_n), .o_irq_n(irq_n), .o_vector(vector), .o_vector_oe(oe));
  pvic_cpu_model i_cpu (.i_ref_clk(clk), .i_rst_n(rst_n), .i_irq_n(irq_n), .i_vector(vector),
    .i_vector_oe(oe), .o_ack_n(ack_n), .o_done_n(done_n), .i_enable(en), .i_eoi(eoi),
    .i_delay(dly), .o_taken(taken), .o_vec_seen(vec_seen));

  // 25 MHz clock
  always #20 clk = ~clk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Rank as group then index, so a HIGH input beats every LOW one
  function automatic int rank(int i);
    return int'(grp[i]) * 16 + i;
  endfunction

  // Highest-ranked eligible input above a floor rank; -1 if none
  function automatic int top(logic [15:0] e, int floor);
    int b;
    b = -1;
    for (int i = 0; i < 16; i++)
      if (e[i] && rank(i) > floor && (b < 0 || rank(i) > rank(b))) b = i;
    return b;
  endfunction

  task automatic tick(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register access: strobe for one cycle, then one idle cycle
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    chk(rdata, exp);
  endtask

  task automatic conclude();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: the sequence needs about 1300 cycles
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  // Reset, configuration in the required order, then random rounds
  initial begin
    tick(4);
    rst_n = 1'b1;
    chk(irq_n, 1'b1);
    rd_reg(8'h36, 8'hff);
    rd_reg(8'h37, 8'hff);
    rd_reg(8'h35, 8'h00);
    rd_reg(8'h30, 8'h00);
    wr_reg(8'h34, trig[7:0]);
    wr_reg(8'h35, trig[15:8]);
    base = 3'(xs());
    wr_reg(8'h37, {base, 5'h00});
    grp = 16'(xs());
    wr_reg(8'h34, grp[7:0]);
    wr_reg(8'h35, grp[15:8]);
    pend = 16'h0000;
    for (it = 0; it < 40; it++) begin
      msk = 16'(xs()) & 16'(xs());
      dly = 2'(xs());
      wr_reg(8'h36, msk[7:0]);
      wr_reg(8'h37, msk[15:8]);
      rd_reg(8'h37, msk[15:8]);
      req = 16'(xs());
      pend = pend | (req & trig); // Rising from all-low requests
      tick(2);
      elig = ((req & ~trig) | pend) & ~msk;
      w = top(elig, -1);
      chk(irq_n, w < 0);
      if (w >= 0) begin
        en = 1'b1;
        for (k = 0; k < 40 && taken !== 1'b1; k++) tick(1);
        en = 1'b0;
        chk(taken, 1'b1);
        chk(vec_seen, {base, 4'(w), 1'b0});
        pend[w] = 1'b0;
        j = xs() % 16;
        if (!req[j] && trig[j]) pend[j] = 1'b1;
        req[j] = 1'b1;
        tick(2);
        elig = ((req & ~trig) | pend) & ~msk;
        chk(irq_n, top(elig, rank(w)) < 0);
        rd_reg(8'h34, 8'(16'h0001 << w));
        rd_reg(8'h35, 8'((16'h0001 << w) >> 8));
        eoi = 1'b1;
        tick(1);
        eoi = 1'b0;
        tick(3);
        rd_reg(8'h34, 8'h00);
        rd_reg(8'h35, 8'h00);
      end
      req = 16'h0000;
      tick(2);
    end
    // Illegal acknowledge: a level request vanishes while the CPU is slow to answer
    wr_reg(8'h36, 8'hfe);
    wr_reg(8'h37, 8'hff);
    req = 16'h0001;
    tick(2);
    chk(irq_n, 1'b0);
    dly = 2'h3;
    en = 1'b1;
    tick(1);
    req = 16'h0000;
    for (k = 0; k < 40 && taken !== 1'b1; k++) tick(1);
    en = 1'b0;
    chk(taken, 1'b1);
    chk(vec_seen, {base, 5'h00});
    req = 16'h0001;
    tick(2);
    chk(irq_n, 1'b1);
    rd_reg(8'h34, 8'h00);
    eoi = 1'b1;
    tick(1);
    eoi = 1'b0;
    tick(3);
    chk(irq_n, 1'b0);
    rd_reg(8'h34, 8'h00);
    req = 16'h0000;
    tick(2);
    conclude();
  end
endmodule
